// [common/iseu_params.svh]
// Constants for the integer store execution unit
// Functional notes
// - Decode byte, half, word, extended stores and their alternate-space forms from opcode_field.
// - Store full 64, low 32, low 16 or low 8 bits of destination register.
// - Address is src_a_reg plus src_b_reg, or plus sign-extended signed_offset_field.
// - Plain stores use the implicit address space of the current context.
// - Each completed store updates memory atomically, never partially visible.
// - Plain store with immediate-select 0 and bits 12:5 nonzero is illegal.
// - Misaligned halfword, word or extended store faults; byte stores never do.
// - Alternate space id comes from instruction field when i=0, register when i=1.
// - Space id bit 7 clear means privileged access, set means non-privileged.
// - Non-privileged alternate store to a privileged space raises privileged-access fault.
// - Privileged alternate store to space id 30 through 7F raises privileged-access fault.
// - Alternate byte, half, word stores accept only the listed spaces, else data-access fault.
// - Alternate extended store faults data-access only for the invalid space set.
// - Stores before a barrier reach memory before any store after it.
// - Store barrier behaves exactly as memory_barrier_op with ordering mask 8.
// - At a barrier the unit may stop issuing until earlier stores are visible.
// - Or it may keep issuing, with later stores visible only after earlier ones.
// - Store barrier with any of bits 12:0 nonzero is illegal; code traps bits 11:0 only, bit 12 set is not decoded as a barrier.
// - Barrier shares opcode_field 10 1000; selected by src_a 15, rd 0, i 0, bit12 0.
`ifndef ISEU_PARAMS_SVH
`define ISEU_PARAMS_SVH

// ----------------------------------------
// Instruction fields
// ----------------------------------------
`define ISEU_OP_MEM          2'h3
`define ISEU_OP_ARITH        2'h2
`define ISEU_SPACE_PLAIN     2'h0
`define ISEU_SPACE_ALT       2'h1
`define ISEU_LOW_BYTE        4'h5
`define ISEU_LOW_HALF        4'h6
`define ISEU_LOW_WORD        4'h4
`define ISEU_LOW_EXT         4'hE
`define ISEU_OPC_BARRIER     6'h28
`define ISEU_BAR_SRC_A       5'h0F
`define ISEU_BAR_MASK        4'h8

// ----------------------------------------
// Address space checks
// ----------------------------------------
`define ISEU_ASI_USER_BIT    7
`define ISEU_ASI_LE_BIT      3
`define ISEU_ASI_PRIV_LO     8'h30
`define ISEU_ASI_PRIV_HI     8'h7F
// One bit per space id, indexed by the id; grouped so each literal is exactly 64 digits
`define ISEU_NARROW_OK 256'h0000_0000_0000_0000_0000_0000_0000_0303_0000_0000_0000_0000_0000_0000_3333_1010
`define ISEU_EXT_BAD   256'h0203_0003_0A0F_2A3F_0000_0000_0000_000C_0000_0000_0000_0000_0000_1010_C0C0_0000

// ----------------------------------------
// Register map
// ----------------------------------------
`define ISEU_REG_CTRL        4'h0
`define ISEU_REG_STATUS      4'h4
`define ISEU_CTRL_OVERLAP    0
`define ISEU_STAT_WAIT       8
`define ISEU_STAT_FENCE      9
`define ISEU_CTRL_RESET      1'h0

`endif

// [common/iseu_pkg.sv]
// Types shared by the integer store execution unit
package iseu_pkg;

  typedef enum logic [1:0] {
    iseu_sz_byte,
    iseu_sz_half,
    iseu_sz_word,
    iseu_sz_ext
  } iseu_size_t;

  typedef enum logic [0:0] {
    iseu_st_idle,
    iseu_st_barwait
  } iseu_state_t;

endpackage

// [src/iseu_asi_check.sv]
// Address space privilege and validity check for alternate stores
`timescale 1ns/100ps
`include "iseu_params.svh"

module iseu_asi_check (
  input  wire logic [7:0] asi_i,
  input  wire logic       is_ext_i,
  input  wire logic       priv_i,
  output logic            priv_fault_o,
  output logic            data_fault_o,
  output logic            little_o
);

  localparam logic [255:0] NARROW_OK = `ISEU_NARROW_OK;
  localparam logic [255:0] EXT_BAD   = `ISEU_EXT_BAD;

  logic user_space;
  logic in_priv_range;

  assign user_space    = asi_i[`ISEU_ASI_USER_BIT];
  assign in_priv_range = (asi_i >= `ISEU_ASI_PRIV_LO) && (asi_i <= `ISEU_ASI_PRIV_HI);

  // Privileged-access faults
  assign priv_fault_o = (!priv_i && !user_space) || (priv_i && in_priv_range);

  // Narrow stores take a short allow list, extended stores a deny list
  assign data_fault_o = is_ext_i ? EXT_BAD[asi_i] : !NARROW_OK[asi_i];

  // Only the known spaces carry an endian meaning in bit 3
  assign little_o = NARROW_OK[asi_i] && asi_i[`ISEU_ASI_LE_BIT];

endmodule

// [src/iseu_store_unit.sv]
// Integer store decode, check and issue unit with barrier ordering
`timescale 1ns/100ps
`include "iseu_params.svh"

module iseu_store_unit #(
  parameter int CNT_W = 8
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Instruction side
  input  wire logic        in_valid_i,
  output logic             in_ready_o,
  input  wire logic [31:0] instr_i,
  input  wire logic [63:0] src_a_reg_i,
  input  wire logic [63:0] src_b_reg_i,
  input  wire logic [63:0] store_val_i,
  input  wire logic [7:0]  asi_reg_i,
  input  wire logic [7:0]  implicit_asi_i,
  input  wire logic        privilege_level_bit_i,
  // Exception report
  output logic             exc_valid_o,
  output logic             exc_illegal_o,
  output logic             exc_misalign_o,
  output logic             exc_priv_o,
  output logic             exc_data_o,
  // Memory side
  output logic             mem_req_o,
  input  wire logic        mem_ready_i,
  output logic [63:0]      mem_addr_o,
  output logic [7:0]       mem_asi_o,
  output logic [63:0]      mem_data_o,
  output logic [1:0]       mem_size_o,
  output logic             mem_order_o,
  input  wire logic        mem_done_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    iseu_pkg::iseu_state_t st;
    logic [CNT_W-1:0]      cnt;
    logic                  fence;
    logic                  req;
    logic [63:0]           addr;
    logic [7:0]            asi;
    logic [63:0]           data;
    iseu_pkg::iseu_size_t  size;
    logic                  order;
    logic                  exc_v;
    logic [3:0]            exc;
    logic                  overlap;
    logic                  ack;
    logic [31:0]           rdat;
  } iseu_regs_t;

  iseu_regs_t s;
  iseu_regs_t next_s;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic [5:0]           opc;
  logic [3:0]           low;
  logic                 imm_sel;
  logic                 is_plain;
  logic                 is_alt;
  logic                 is_store;
  logic                 bar_sel;
  logic                 bar_ill;
  iseu_pkg::iseu_size_t sz;
  logic [63:0]          offset;
  logic [63:0]          ea;
  logic [7:0]           asi_sel;
  logic [2:0]           align_mask;
  logic                 st_ill;
  logic                 st_mis;
  logic                 asi_priv_f;
  logic                 asi_data_f;
  logic                 asi_little;
  logic                 fault;
  logic [63:0]          val;
  logic [63:0]          rev;
  logic [63:0]          swapped;
  logic                 fire;
  logic                 issue_done;
  logic                 cnt_full;
  logic [CNT_W-1:0]     cnt_next;

  assign opc     = instr_i[24:19];
  assign low     = opc[3:0];
  assign imm_sel = instr_i[13];
  assign is_plain = (instr_i[31:30] == `ISEU_OP_MEM) && (opc[5:4] == `ISEU_SPACE_PLAIN);
  assign is_alt   = (instr_i[31:30] == `ISEU_OP_MEM) && (opc[5:4] == `ISEU_SPACE_ALT);

  always_comb
  begin
    sz = iseu_pkg::iseu_sz_byte;
    is_store = is_plain || is_alt;
    case (low)
      `ISEU_LOW_BYTE: sz = iseu_pkg::iseu_sz_byte;
      `ISEU_LOW_HALF: sz = iseu_pkg::iseu_sz_half;
      `ISEU_LOW_WORD: sz = iseu_pkg::iseu_sz_word;
      `ISEU_LOW_EXT:  sz = iseu_pkg::iseu_sz_ext;
      default:        is_store = 1'b0;
    endcase
  end

  // Barrier shares its opcode with two other instructions
  assign bar_sel = (instr_i[31:30] == `ISEU_OP_ARITH) && (opc == `ISEU_OPC_BARRIER)
                   && (instr_i[18:14] == `ISEU_BAR_SRC_A) && (instr_i[29:25] == 5'h00)
                   && !imm_sel && !instr_i[12];
  assign bar_ill = bar_sel && (|instr_i[12:0]);

  assign offset = imm_sel ? {{51{instr_i[12]}}, instr_i[12:0]} : src_b_reg_i;
  assign ea     = src_a_reg_i + offset;

  // Alternate id from field or register; plain uses context id
  assign asi_sel = is_alt ? (imm_sel ? asi_reg_i : instr_i[12:5]) : implicit_asi_i;

  always_comb
  begin
    case (sz)
      iseu_pkg::iseu_sz_half: align_mask = 3'h1;
      iseu_pkg::iseu_sz_word: align_mask = 3'h3;
      iseu_pkg::iseu_sz_ext:  align_mask = 3'h7;
      default:                align_mask = 3'h0;
    endcase
  end

  assign st_ill = is_plain && !imm_sel && (|instr_i[12:5]);
  assign st_mis = |(ea[2:0] & align_mask);

  iseu_asi_check u_asi_check (
    .asi_i        (asi_sel),
    .is_ext_i     (sz == iseu_pkg::iseu_sz_ext),
    .priv_i       (privilege_level_bit_i),
    .priv_fault_o (asi_priv_f),
    .data_fault_o (asi_data_f),
    .little_o     (asi_little)
  );

  assign fault = st_ill || st_mis || (is_alt && (asi_priv_f || asi_data_f));

  // ----------------------------------------
  // Store data
  // ----------------------------------------
  always_comb
  begin
    case (sz)
      iseu_pkg::iseu_sz_byte: val = {56'h0, store_val_i[7:0]};
      iseu_pkg::iseu_sz_half: val = {48'h0, store_val_i[15:0]};
      iseu_pkg::iseu_sz_word: val = {32'h0, store_val_i[31:0]};
      default:                val = store_val_i;
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_rev
      assign rev[8*gi +: 8] = val[8*(7-gi) +: 8];
    end
  endgenerate

  // Reversal lands in the top bytes, shift back to the low end
  always_comb
  begin
    case (sz)
      iseu_pkg::iseu_sz_byte: swapped = rev >> 56;
      iseu_pkg::iseu_sz_half: swapped = rev >> 48;
      iseu_pkg::iseu_sz_word: swapped = rev >> 32;
      default:                swapped = rev;
    endcase
  end

  // ----------------------------------------
  // Handshakes
  // ----------------------------------------
  assign issue_done = s.req && mem_ready_i;
  assign cnt_full   = &s.cnt;
  assign in_ready_o = (s.st == iseu_pkg::iseu_st_idle) && (!s.req || mem_ready_i) && !cnt_full;
  assign fire       = in_valid_i && in_ready_o;
  assign cnt_next   = s.cnt + CNT_W'(issue_done) - CNT_W'(mem_done_i);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_s       = s;
    next_s.cnt   = cnt_next;
    next_s.exc_v = 1'b0;
    next_s.ack   = wb_cyc_i && wb_stb_i && !s.ack;
    // Fence stays while any store, from before or after the barrier, is still in flight
    next_s.fence = s.fence && (cnt_next != '0);
    if (issue_done)
    begin
      next_s.req = 1'b0;
    end
    if (s.st == iseu_pkg::iseu_st_barwait && s.cnt == '0 && !s.req)
    begin
      next_s.st = iseu_pkg::iseu_st_idle;
    end
    if (fire && is_store)
    begin
      if (fault)
      begin
        next_s.exc_v = 1'b1;
        // Priority: illegal, privileged, data access, alignment
        if (st_ill)
          next_s.exc = 4'h1;
        else if (is_alt && asi_priv_f)
          next_s.exc = 4'h4;
        else if (is_alt && asi_data_f)
          next_s.exc = 4'h8;
        else
          next_s.exc = 4'h2;
      end
      else
      begin
        // One beat per store so memory sees the value whole
        next_s.req   = 1'b1;
        next_s.addr  = ea;
        next_s.asi   = asi_sel;
        next_s.size  = sz;
        next_s.data  = (is_alt && asi_little) ? swapped : val;
        next_s.order = s.fence;
      end
    end
    if (fire && bar_sel)
    begin
      if (bar_ill)
      begin
        next_s.exc_v = 1'b1;
        next_s.exc   = 4'h1;
      end
      else if (s.overlap)
      begin
        // Keep issuing; later stores are tagged to wait for older ones
        next_s.fence = (cnt_next != '0) || (s.req && !issue_done);
      end
      else
      begin
        next_s.st = iseu_pkg::iseu_st_barwait;
      end
    end
    // Register bus
    if (next_s.ack)
    begin
      case (wb_adr_i)
        `ISEU_REG_CTRL:   next_s.rdat = {31'h0, s.overlap};
        `ISEU_REG_STATUS: next_s.rdat = 32'(s.cnt) | {22'h0, s.fence, s.st == iseu_pkg::iseu_st_barwait, 8'h0};
        default:          next_s.rdat = 32'h0;
      endcase
    end
    if (s.ack && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_adr_i == `ISEU_REG_CTRL)
    begin
      next_s.overlap = wb_dat_i[`ISEU_CTRL_OVERLAP];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s         <= '0;
      s.st      <= iseu_pkg::iseu_st_idle;
      s.size    <= iseu_pkg::iseu_sz_byte;
      s.overlap <= `ISEU_CTRL_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign exc_valid_o    = s.exc_v;
  assign exc_illegal_o  = s.exc_v && s.exc[0];
  assign exc_misalign_o = s.exc_v && s.exc[1];
  assign exc_priv_o     = s.exc_v && s.exc[2];
  assign exc_data_o     = s.exc_v && s.exc[3];
  assign mem_req_o      = s.req;
  assign mem_addr_o     = s.addr;
  assign mem_asi_o      = s.asi;
  assign mem_data_o     = s.data;
  assign mem_size_o     = s.size;
  assign mem_order_o    = s.req && s.order;
  assign wb_dat_o       = s.rdat;
  assign wb_ack_o       = s.ack;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  barrier_stall_a: assert property (s.st == iseu_pkg::iseu_st_barwait |-> !in_ready_o)
    else $error("instruction taken while barrier waits");

  barrier_release_a: assert property (
    s.st == iseu_pkg::iseu_st_barwait && s.cnt == '0 && !mem_req_o && !mem_done_i
    |=> s.st == iseu_pkg::iseu_st_idle ##1 (s.st == iseu_pkg::iseu_st_idle || $past(fire && bar_sel)))
    else $error("barrier did not release when drained");

  req_hold_a: assert property (mem_req_o && !mem_ready_i
    |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_data_o))
    else $error("store request changed before accept");

  align_out_a: assert property (mem_req_o |-> (mem_addr_o[2:0] & ((3'h1 << mem_size_o) - 3'h1)) == 3'h0)
    else $error("misaligned store reached memory");

  byte_width_a: assert property (mem_req_o && mem_size_o == iseu_pkg::iseu_sz_byte |-> mem_data_o[63:8] == 56'h0)
    else $error("byte store carries upper bits");

  ea_imm_a: assert property (fire && is_store && !fault && imm_sel
    |=> mem_req_o && mem_addr_o == $past(src_a_reg_i) + {{51{$past(instr_i[12])}}, $past(instr_i[12:0])})
    else $error("immediate address wrong");

  plain_asi_a: assert property (fire && is_plain && is_store && !fault
    |=> mem_asi_o == $past(implicit_asi_i))
    else $error("plain store used wrong space");

  alt_field_a: assert property (fire && is_alt && is_store && !fault && !imm_sel
    |=> mem_asi_o == $past(instr_i[12:5]))
    else $error("alternate space field not used");

  user_priv_a: assert property (fire && is_alt && is_store && !privilege_level_bit_i && !asi_sel[7]
    |=> exc_valid_o && exc_priv_o && !mem_req_o)
    else $error("user access to privileged space not trapped");

  // A new instruction taken right after may raise its own exception
  bar_illegal_a: assert property (fire && bar_sel && (|instr_i[11:0])
    |=> exc_illegal_o ##1 (!exc_valid_o || $past(fire)))
    else $error("bad barrier encoding not trapped");

endmodule

// [dv/iseu_mem_model.sv]
// Behavioural memory subsystem facing the store unit
`timescale 1ns/100ps
module iseu_mem_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic stall_i,
  input  wire logic hold_i,
  input  wire logic mem_req_i,
  output logic      mem_ready_o,
  output logic      mem_done_o
);
  logic [7:0] pend;
  // Whole store taken in one beat, so nothing partial is seen
  assign mem_ready_o = !stall_i;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pend       <= 8'h00;
      mem_done_o <= 1'b0;
    end
    else
    begin
      // Hold keeps stores invisible, to stretch a barrier wait
      mem_done_o <= (pend != 8'h00) && !hold_i && !mem_done_o;
      pend       <= pend + {7'h00, mem_req_i && mem_ready_o} - {7'h00, mem_done_o};
    end
  end
endmodule

// [dv/test_integer_store_exec_unit.sv]
// Self-checking bench for the integer store unit
`timescale 1ns/100ps
module test_integer_store_exec_unit;
  logic clk = 1'b0, rst = 1'b1, in_valid = 1'b0, priv = 1'b0, stall = 1'b0, hold = 1'b0;
  logic [31:0] instr = 32'h0, wb_dat = 32'h0, wb_dat_o;
  logic [63:0] src_a = 64'h0, src_b = 64'h0, st_val = 64'h0, mem_addr_o, mem_data_o, ad, dt;
  logic [7:0] asi_reg = 8'h00, mem_asi_o, as;
  logic [3:0] wb_adr = 4'h0, wb_sel = 4'h0, lo [4] = '{4'h5, 4'h6, 4'h4, 4'hE};
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack_o, rq, od, in_ready_o, mem_req_o, mem_ready, mem_done;
  logic exc_valid_o, exc_illegal_o, exc_misalign_o, exc_priv_o, exc_data_o, mem_order_o;
  logic [4:0] xv;
  logic [1:0] mem_size_o, sz;
  int err_count = 0, checks_done = 0;
  always #4 clk = ~clk;
  iseu_store_unit #(.CNT_W(8)) u_dut (.clk_i(clk), .rst_i(rst), .in_valid_i(in_valid), .in_ready_o(in_ready_o),
    .instr_i(instr), .src_a_reg_i(src_a), .src_b_reg_i(src_b), .store_val_i(st_val), .asi_reg_i(asi_reg),
    .implicit_asi_i(8'h5A), .privilege_level_bit_i(priv), .exc_valid_o(exc_valid_o), .exc_illegal_o(exc_illegal_o),
    .exc_misalign_o(exc_misalign_o), .exc_priv_o(exc_priv_o), .exc_data_o(exc_data_o), .mem_req_o(mem_req_o),
    .mem_ready_i(mem_ready), .mem_addr_o(mem_addr_o), .mem_asi_o(mem_asi_o), .mem_data_o(mem_data_o),
    .mem_size_o(mem_size_o), .mem_order_o(mem_order_o), .mem_done_i(mem_done), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  iseu_mem_model u_mem (.clk_i(clk), .rst_i(rst), .stall_i(stall), .hold_i(hold), .mem_req_i(mem_req_o),
    .mem_ready_o(mem_ready), .mem_done_o(mem_done));
  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d, output logic [31:0] q);
    wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= we; wb_adr <= adr; wb_dat <= d;
    wb_sel <= 4'hF;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc <= 1'b0; wb_stb <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [31:0] ins(input logic [5:0] opc, input logic i, input logic [12:0] low);
    return {2'h3, 5'h03, opc, 5'h01, i, low};
  endfunction
  // Offer one instruction, capture what it produced 1ns after the edge that takes it
  task automatic run(input logic [31:0] ins_w, input logic [63:0] a, b, v, input logic [7:0] ar, input logic pv);
    in_valid <= 1'b1; instr <= ins_w; src_a <= a; src_b <= b; st_val <= v; asi_reg <= ar; priv <= pv;
    do @(posedge clk); while (in_ready_o !== 1'b1);
    in_valid <= 1'b0;
    #1;
    xv = {exc_valid_o, exc_illegal_o, exc_priv_o, exc_data_o, exc_misalign_o};
    rq = mem_req_o; ad = mem_addr_o; dt = mem_data_o; as = mem_asi_o; sz = mem_size_o; od = mem_order_o;
    @(posedge clk);
  endtask
  task automatic res(input logic [3:0] e, input logic r);
    chk("exception", {59'h0, xv}, {59'h0, |e, e});
    chk("request", {63'h0, rq}, {63'h0, r});
  endtask
  task automatic t_regs();
    logic [31:0] q;
    wb(1'b0, 4'h0, 32'h0, q); chk("ctrl reset", q, 64'h0);
    wb(1'b1, 4'h8, 32'hFFFFFFFF, q); wb(1'b0, 4'h8, 32'h0, q); chk("unmapped", q, 64'h0);
    wb(1'b1, 4'h4, 32'hFFFFFFFF, q); wb(1'b0, 4'h4, 32'h0, q); chk("status ro", q, 64'h0);
  endtask
  task automatic t_plain();
    logic [63:0] m;
    for (int k = 0; k < 4; k++)
    begin
      m = (k == 3) ? 64'hFFFFFFFFFFFFFFFF : (64'h1 << (8 << k)) - 64'h1;
      run(ins({2'h0, lo[k]}, 1'b1, 13'h1FF8), 64'h1000, 64'h0, 64'h8899AABBCCDDEEFF, 8'hC3, 1'b0);
      res(4'h0, 1'b1);
      chk("addr imm", ad, 64'hFF8);
      chk("implicit asi", {56'h0, as}, 64'h5A);
      chk("size", {62'h0, sz}, k);
      chk("data", dt & m, 64'h8899AABBCCDDEEFF & m);
    end
    run(ins(6'h0E, 1'b0, 13'h001F), 64'h100, 64'h20, 64'h0, 8'h00, 1'b0);
    res(4'h0, 1'b1);
    chk("addr reg", ad, 64'h120);
    run(ins(6'h0E, 1'b0, 13'h0020), 64'h100, 64'h20, 64'h0, 8'h00, 1'b0);
    res(4'h8, 1'b0);
  endtask
  task automatic t_align();
    for (int k = 0; k < 4; k++)
    begin
      run(ins({2'h0, lo[k]}, 1'b1, 13'h0), (64'h2 << k) >> 2 | (k == 0), 64'h0, 64'h0, 8'h80, 1'b1);
      res((k == 0) ? 4'h0 : 4'h1, k == 0);
      run(ins({2'h1, lo[k]}, 1'b1, 13'h0), (64'h2 << k) >> 2 | (k == 0), 64'h0, 64'h0, 8'h80, 1'b1);
      res((k == 0) ? 4'h0 : 4'h1, k == 0);
    end
  endtask
  task automatic t_alt();
    logic [7:0] al [8] = '{8'h04, 8'h80, 8'h30, 8'h7F, 8'h24, 8'h2C, 8'h82, 8'h04};
    logic [3:0] ex [8] = '{4'h4, 4'h0, 4'h4, 4'h4, 4'h2, 4'h2, 4'h2, 4'h0};
    run(ins(6'h14, 1'b0, {8'h88, 5'h00}), 64'h40, 64'h0, 64'h11223344, 8'h00, 1'b1);
    res(4'h0, 1'b1);
    chk("imm asi", {56'h0, as}, 64'h88);
    chk("little word", dt & 64'hFFFFFFFF, 64'h44332211);
    run(ins(6'h1E, 1'b0, {8'h89, 5'h00}), 64'h40, 64'h0, 64'h0102030405060708, 8'h00, 1'b1);
    chk("little ext", dt, 64'h0807060504030201);
    run(ins(6'h16, 1'b1, 13'h1F00), 64'h40, 64'h0, 64'hA1B2, 8'h81, 1'b1);
    chk("reg asi", {56'h0, as}, 64'h81);
    chk("big half", dt & 64'hFFFF, 64'hA1B2);
    for (int j = 0; j < 8; j++)
    begin
      run(ins((j > 2 && j < 6) ? 6'h1E : 6'h14, 1'b1, 13'h0), 64'h40, 64'h0, 64'h0, al[j], j != 0 && j != 1);
      res(ex[j], ex[j] == 4'h0);
    end
    run(ins(6'h16, 1'b1, 13'h0), 64'h41, 64'h0, 64'h0, 8'h04, 1'b0);
    res(4'h4, 1'b0);
  endtask
  task automatic t_bar_stall();
    logic [31:0] q;
    hold <= 1'b1;
    run(ins(6'h0E, 1'b1, 13'h0), 64'h200, 64'h0, 64'h5, 8'h00, 1'b0);
    run({2'h2, 5'h00, 6'h28, 5'h0F, 1'b0, 13'h0800}, 64'h0, 64'h0, 64'h0, 8'h00, 1'b0);
    res(4'h8, 1'b0);
    run({2'h2, 5'h00, 6'h28, 5'h0F, 1'b0, 13'h0000}, 64'h0, 64'h0, 64'h0, 8'h00, 1'b0);
    res(4'h0, 1'b0);
    wb(1'b0, 4'h4, 32'h0, q); chk("status wait", q, 64'h101);
    fork
      begin
        repeat (6) @(posedge clk);
        chk("held store", {63'h0, mem_req_o}, 64'h0);
        hold <= 1'b0;
      end
    join_none
    run(ins(6'h0E, 1'b1, 13'h0), 64'h208, 64'h0, 64'h6, 8'h00, 1'b0);
    res(4'h0, 1'b1);
    chk("addr after", ad, 64'h208);
  endtask
  task automatic t_bar_overlap();
    logic [31:0] q;
    wb(1'b1, 4'h0, 32'h1, q); wb(1'b0, 4'h0, 32'h0, q); chk("ctrl rw", q, 64'h1);
    hold <= 1'b1; stall <= 1'b1;
    run(ins(6'h0E, 1'b1, 13'h0), 64'h300, 64'h0, 64'h7, 8'h00, 1'b0);
    chk("order before", {63'h0, od}, 64'h0);
    stall <= 1'b0;
    run({2'h2, 5'h00, 6'h28, 5'h0F, 1'b0, 13'h0}, 64'h0, 64'h0, 64'h0, 8'h00, 1'b0);
    run(ins(6'h0E, 1'b1, 13'h0), 64'h308, 64'h0, 64'h8, 8'h00, 1'b0);
    res(4'h0, 1'b1);
    chk("order after", {63'h0, od}, 64'h1);
    wb(1'b0, 4'h4, 32'h0, q); chk("status fence", q, 64'h202);
    hold <= 1'b0;
    repeat (12) @(posedge clk);
    wb(1'b0, 4'h4, 32'h0, q); chk("drained", q, 64'h0);
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_plain();
    t_align();
    t_alt();
    t_bar_stall();
    t_bar_overlap();
    final_report();
  end
  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    err_count++;
    final_report();
  end
endmodule
